// ===== dv/mfm_write_precomp_phase_detect_tb.sv
/*
  Bench for the precompensation and phase detector block.
  Assumes the controller model beside it and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfmpc_params.svh"
module mfm_write_precomp_phase_detect_tb;
  localparam int DLY = 40;
  localparam int TICK = `MFMPC_SHIFT_CYC;
  logic clk_i;
  logic reset_i = 1'h1;
  logic disk = 1'h0;
  logic osc = 1'h0;
  logic wr_req = 1'h0;
  logic early = 1'h0;
  logic late = 1'h0;
  logic track = 1'h1;
  logic dbl = 1'h0;
  logic saw_l = 1'h0;
  logic saw_r = 1'h0;
  logic [3:0] cnt = 4'h0;
  wire logic ctrl, four_n, wp_n, e_c, l_c, trk, dblc;
  logic lower, raise_n, cmp, last_n, wdat, oe_n, wready;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t_e, t_n, t_l;

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  mfmpc_fdc_model fdc (.clk_i(clk_i), .reset_i(reset_i), .write_ready_i(wready),
    .wr_req_i(wr_req), .early_i(early), .late_i(late), .track_i(track), .dbl_i(dbl),
    .controller_clock_o(ctrl), .four_meg_clock_n_o(four_n), .serial_write_pulse_in_n_o(wp_n),
    .early_cmd_o(e_c), .late_cmd_o(l_c), .osc_track_enable_o(trk),
    .double_rate_write_clock_o(dblc));

  mfmpc_top #(.DATA_DELAY_CYC(8'(DLY))) uut (.clk_i(clk_i), .reset_i(reset_i),
    .disk_data_i(disk), .double_rate_write_clock_i(dblc), .osc_track_enable_i(trk),
    .osc_clock_i(osc), .serial_write_pulse_in_n_i(wp_n), .controller_clock_i(ctrl),
    .four_meg_clock_n_i(four_n), .early_cmd_i(e_c), .late_cmd_i(l_c),
    .lower_freq_o(lower), .raise_freq_n_o(raise_n), .comparison_clock_o(cmp),
    .last_stage_out_n_o(last_n), .write_data_o(wdat), .write_data_oe_n_o(oe_n),
    .write_ready_o(wready));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ****************
  // Cycle count, timeout and per-cycle watch
  // ****************
  always @(posedge clk_i) begin
    cyc <= reset_i ? 0 : cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      give_verdict();
    end
    if (!reset_i) begin
      if (lower === 1'h1) saw_l <= 1'h1;
      if (raise_n === 1'h0) saw_r <= 1'h1;
      chk(lower & ~raise_n, 16'h0);
      chk(oe_n, !last_n);
      chk(wdat, 16'h0);
    end
  end

  task automatic osc_n(input int k);
    repeat (k) begin
      @(posedge clk_i) osc <= 1'h1;
      repeat (3) @(posedge clk_i);
      osc <= 1'h0;
      repeat (4) @(posedge clk_i);
      cnt = cnt + 4'h1;
    end
    #1;
    chk(cmp, cnt[2]);
  endtask

  task automatic pulse(input logic use_dbl);
    @(posedge clk_i);
    if (use_dbl) dbl <= 1'h1;
    else disk <= 1'h1;
    repeat (3) @(posedge clk_i);
    disk <= 1'h0;
    dbl <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic clear_seen();
    @(posedge clk_i);
    saw_l <= 1'h0;
    saw_r <= 1'h0;
  endtask

  task automatic t_lower();
    osc_n(3);
    pulse(1'h0);
    osc_n(1);
    wait_cyc(2);
    chk(lower, 16'h1);
    wait_cyc(20);
    chk(lower, 16'h1);
    wait_cyc(30);
    chk(lower, 16'h0);
    $display("test lower done");
  endtask

  task automatic t_raise();
    osc_n(7);
    pulse(1'h0);
    wait_cyc(DLY + 10);
    chk(raise_n, 16'h0);
    chk(lower, 16'h0);
    osc_n(1);
    wait_cyc(3);
    chk(raise_n, 16'h1);
    $display("test raise done");
  endtask

  task automatic t_coinc();
    osc_n(15);
    clear_seen();
    fork
      pulse(1'h0);
      begin
        repeat (DLY) @(posedge clk_i);
        osc_n(1);
      end
    join
    wait_cyc(DLY);
    chk(saw_l, 16'h0);
    chk(saw_r, 16'h0);
    clear_seen();
    osc_n(8);
    wait_cyc(4);
    chk(saw_l, 16'h0);
    $display("test coincidence done");
  endtask

  task automatic t_track();
    @(posedge clk_i) track <= 1'h0;
    wait_cyc(8);
    clear_seen();
    pulse(1'h0);
    wait_cyc(DLY + 10);
    chk(saw_r | saw_l, 16'h0);
    pulse(1'h1);
    wait_cyc(DLY + 10);
    chk(raise_n, 16'h0);
    osc_n(8);
    wait_cyc(3);
    chk(raise_n, 16'h1);
    @(posedge clk_i) track <= 1'h1;
    wait_cyc(8);
    $display("test tracking done");
  endtask

  // Same phase of every free clock at each request, so only the command moves the bit
  task automatic wr(input logic e, input logic l, output int t);
    int w;
    do begin
      wait_cyc(1);
    end while (cyc % 300 != 0);
    chk(wready, 16'h1);
    @(posedge clk_i);
    wr_req <= 1'h1;
    early <= e;
    late <= l;
    @(posedge clk_i) wr_req <= 1'h0;
    t = 0;
    w = 0;
    while (last_n !== 1'h0 && t < 600) begin
      wait_cyc(1);
      t++;
    end
    while (last_n === 1'h0 && w < 100) begin
      wait_cyc(1);
      w++;
    end
    chk(16'(w), 16'(TICK));
  endtask

  task automatic t_write();
    wr(1'h1, 1'h0, t_e);
    wr(1'h0, 1'h0, t_n);
    wr(1'h0, 1'h1, t_l);
    chk(16'(t_n < 600), 16'h1);
    chk(16'(t_n - t_e), 16'(TICK));
    chk(16'(t_l - t_n), 16'(TICK));
    $display("test write done");
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (11) @(posedge clk_i);
    #1;
    chk({lower, raise_n, cmp, last_n, oe_n, wready}, 16'h15);
    @(posedge clk_i) reset_i <= 1'h0;
    wait_cyc(8);
    t_lower();
    t_raise();
    t_coinc();
    t_track();
    t_write();
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== dv/mfmpc_fdc_model.sv
/*
  Controller side model: free clocks, write pulses, commands, tracking.
  Assumes the bench asks for writes and tracking through level inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module mfmpc_fdc_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic write_ready_i,
  input wire logic wr_req_i,
  input wire logic early_i,
  input wire logic late_i,
  input wire logic track_i,
  input wire logic dbl_i,
  output logic controller_clock_o,
  output logic four_meg_clock_n_o,
  output logic serial_write_pulse_in_n_o,
  output logic early_cmd_o,
  output logic late_cmd_o,
  output logic osc_track_enable_o,
  output logic double_rate_write_clock_o
);
  logic [5:0] cc;
  logic [4:0] c4;
  logic [3:0] pw;
  // ****************
  // Free clocks, phase fixed by reset so write timing repeats
  // ****************
  always_ff @(posedge clk_i) begin
    cc <= (reset_i || cc == 6'h31) ? 6'h0 : cc + 6'h1;
    c4 <= (reset_i || c4 == 5'h18) ? 5'h0 : c4 + 5'h1;
    controller_clock_o <= cc < 6'h19;
    four_meg_clock_n_o <= c4 < 5'h0c;
  end
  // ****************
  // Write pulse, issued only while the block is ready
  // ****************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pw <= 4'h0;
      early_cmd_o <= 1'h0;
      late_cmd_o <= 1'h0;
    end else if (wr_req_i && write_ready_i && pw == 4'h0) begin
      pw <= 4'h8;
      early_cmd_o <= early_i;
      late_cmd_o <= late_i;
    end else if (pw != 4'h0) begin
      pw <= pw - 4'h1;
    end
  end
  assign serial_write_pulse_in_n_o = (pw == 4'h0);
  always_ff @(posedge clk_i) begin
    osc_track_enable_o <= reset_i ? 1'h0 : track_i;
    double_rate_write_clock_o <= reset_i ? 1'h0 : dbl_i;
  end
endmodule
`default_nettype wire

// ===== src/mfmpc_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mfmpc_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/mfmpc_params.svh
/*
  Constants for the write precompensation and phase detector block.
  Assumes a 100 MHz clk_i and pins that are asynchronous to it.
*/
// Summary of operation
// - Comparison clock before delayed data gives a lower-frequency pulse.
// - Lower pulse runs from clock edge to delayed data edge.
// - Data before clock gives active-low raise pulse, width equals error.
// - Comparison clock is bit two of a 4-bit oscillator counter.
// - Tracking disabled selects the double-rate write clock as detector input.
// - Raise and lower never active together, neither on exact coincidence.
// - On coincidence both detector flops set briefly, then both reset.
// - With only one detector flop set, detection keeps running.
// - Write pulse synchronised to controller clock and 4 MHz clock before load.
// - Parallel inputs settle before the commands are latched and shifting begins.
// - Advance loads at stage C and leaves 120 ns early.
// - Retard loads at stage A and leaves 120 ns late.
// - Neither command loads their combined condition at stage B, nominal time.
// - Write output is inverted last stage through open-collector inverter.
// - Detector is enabled then disabled once per selected input pulse: disk data when tracking, else the write clock.
// - Both inverted detector outputs low sets enable flop, clearing both.
`ifndef MFMPC_PARAMS_SVH
`define MFMPC_PARAMS_SVH

// ****************
// Timing
// ****************
`define MFMPC_CLK_MHZ 100
`define MFMPC_SHIFT_NS 125
`define MFMPC_SHIFT_CYC ((`MFMPC_SHIFT_NS * `MFMPC_CLK_MHZ) / 1000)
`define MFMPC_DATA_DELAY_CYC 20

// ****************
// Field positions
// ****************
`define MFMPC_CNT_W 4
`define MFMPC_CMP_BIT 2
`define MFMPC_SR_W 4
`define MFMPC_STAGE_D 0
`define MFMPC_STAGE_C 1
`define MFMPC_STAGE_B 2
`define MFMPC_STAGE_A 3
`define MFMPC_BUSY_TICKS 4
`define MFMPC_CMD_W 2

// ****************
// Pin order in the synchroniser bank
// ****************
`define MFMPC_NPIN 9
`define MFMPC_P_DISK 0
`define MFMPC_P_DBL 1
`define MFMPC_P_TRACK 2
`define MFMPC_P_WP_N 3
`define MFMPC_P_CTRL 4
`define MFMPC_P_FOUR_N 5
`define MFMPC_P_OSC 6
`define MFMPC_P_EARLY 7
`define MFMPC_P_LATE 8

`endif

// ===== src/mfmpc_pkg.sv
/*
  Types for the write precompensation and phase detector block.
  Assumes nothing beyond the params header.
*/
package mfmpc_pkg;
  typedef enum logic [1:0] {
    P_IDLE,
    P_SYNC,
    P_SETTLE,
    P_PUSH
  } mfmpc_load_t;
endpackage

// ===== src/mfmpc_top.sv
/*
  Write precompensation shift register and read data phase detector.
  Assumes all pins asynchronous to clk_i; oscillator and filter outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfmpc_params.svh"
module mfmpc_top
  import mfmpc_pkg::*;
#(
  parameter logic [7:0] DATA_DELAY_CYC = 8'(`MFMPC_DATA_DELAY_CYC),
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic disk_data_i,
  input wire logic double_rate_write_clock_i,
  input wire logic osc_track_enable_i,
  input wire logic osc_clock_i,
  input wire logic serial_write_pulse_in_n_i,
  input wire logic controller_clock_i,
  input wire logic four_meg_clock_n_i,
  input wire logic early_cmd_i,
  input wire logic late_cmd_i,
  output logic lower_freq_o,
  output logic raise_freq_n_o,
  output logic comparison_clock_o,
  output logic last_stage_out_n_o,
  output logic write_data_o,
  output logic write_data_oe_n_o,
  output logic write_ready_o
);
  // ****************
  // Pin synchronisers
  // ****************
  logic [`MFMPC_NPIN-1:0] pins;
  logic [`MFMPC_NPIN-1:0] s1;
  logic [`MFMPC_NPIN-1:0] s2;
  logic [`MFMPC_NPIN-1:0] s3;
  logic [`MFMPC_NPIN-1:0] f;
  logic [`MFMPC_NPIN-1:0] f_prev;

  assign pins = {late_cmd_i, early_cmd_i, osc_clock_i, four_meg_clock_n_i,
                 controller_clock_i, serial_write_pulse_in_n_i,
                 osc_track_enable_i, double_rate_write_clock_i, disk_data_i};

  genvar gi;
  generate
    for (gi = 0; gi < `MFMPC_NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        s1[gi] <= pins[gi];
        s2[gi] <= s1[gi];
        s3[gi] <= s2[gi];
      end
      // Change counts only once two stages agree
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          f[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          f[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      f_prev <= '0;
    end else begin
      f_prev <= f;
    end
  end

  // ****************
  // Oscillator counter
  // ****************
  logic [`MFMPC_CNT_W-1:0] osc_cnt;
  logic osc_rise;
  logic cmp_rise;

  assign osc_rise = f[`MFMPC_P_OSC] && !f_prev[`MFMPC_P_OSC];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_cnt <= '0;
    end else if (osc_rise) begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      comparison_clock_o <= 1'b0;
    end else begin
      comparison_clock_o <= osc_cnt[`MFMPC_CMP_BIT];
    end
  end

  assign cmp_rise = osc_cnt[`MFMPC_CMP_BIT] && !comparison_clock_o;

  // ****************
  // Detector input and data delay
  // ****************
  logic sel_now;
  logic sel_prev;
  logic sel_rise;
  logic [7:0] dly_cnt;
  logic dly_edge;

  // Idle drive keeps the loop near nominal
  assign sel_now = f[`MFMPC_P_TRACK] ? f[`MFMPC_P_DISK] : f[`MFMPC_P_DBL];
  assign sel_rise = sel_now && !sel_prev;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dly_cnt <= '0;
      dly_edge <= 1'b0;
    end else begin
      dly_edge <= (dly_cnt == 8'h01);
      if (sel_rise) begin
        dly_cnt <= DATA_DELAY_CYC;
      end else if (dly_cnt != '0) begin
        dly_cnt <= dly_cnt - 1'b1;
      end
    end
  end

  // ****************
  // Phase detector
  // ****************
  logic det_off;
  logic clk_ff;
  logic data_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      det_off <= 1'b1;
      clk_ff <= 1'b0;
      data_ff <= 1'b0;
    end else if (clk_ff && data_ff) begin
      det_off <= 1'b1;
      clk_ff <= 1'b0;
      data_ff <= 1'b0;
    end else begin
      if (sel_rise) begin
        det_off <= 1'b0;
      end
      // Only one set: gate stays low, keep measuring
      if (!det_off && cmp_rise) begin
        clk_ff <= 1'b1;
      end
      if (!det_off && dly_edge) begin
        data_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lower_freq_o <= 1'b0;
      raise_freq_n_o <= 1'b1;
    end else begin
      lower_freq_o <= clk_ff && !data_ff;
      raise_freq_n_o <= !(data_ff && !clk_ff);
    end
  end

  // ****************
  // Shift tick divider
  // ****************
  localparam int TICK_SPAN = `MFMPC_SHIFT_CYC;
  logic [7:0] div_cnt;
  logic shift_tick;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt <= '0;
      shift_tick <= 1'b0;
    end else begin
      shift_tick <= (div_cnt == 8'(`MFMPC_SHIFT_CYC - 1));
      div_cnt <= (div_cnt == 8'(`MFMPC_SHIFT_CYC - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  // ****************
  // Write pulse capture
  // ****************
  mfmpc_load_t state;
  logic wp_fall;
  logic sync_ok;
  logic push_valid;
  logic [`MFMPC_CMD_W-1:0] push_cmd;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic [`MFMPC_CMD_W-1:0] buf_cmd;

  assign wp_fall = !f[`MFMPC_P_WP_N] && f_prev[`MFMPC_P_WP_N];
  assign sync_ok = f[`MFMPC_P_CTRL] && !f[`MFMPC_P_FOUR_N] && f_prev[`MFMPC_P_FOUR_N];
  assign write_ready_o = (state == P_IDLE);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= P_IDLE;
      push_valid <= 1'b0;
      push_cmd <= '0;
    end else begin
      case (state)
        P_IDLE: begin
          if (wp_fall) begin
            state <= P_SYNC;
          end
        end
        P_SYNC: begin
          if (sync_ok) begin
            state <= P_SETTLE;
          end
        end
        P_SETTLE: begin
          // Waiting for the next shift tick lets the command pins settle
          if (shift_tick) begin
            push_cmd <= {f[`MFMPC_P_EARLY], f[`MFMPC_P_LATE]};
            push_valid <= 1'b1;
            state <= P_PUSH;
          end
        end
        P_PUSH: begin
          if (buf_in_ready) begin
            push_valid <= 1'b0;
            state <= P_IDLE;
          end
        end
        default: begin
          state <= P_IDLE;
        end
      endcase
    end
  end

  mfmpc_buffer #(
    .WIDTH(`MFMPC_CMD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(push_cmd),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_cmd)
  );

  // ****************
  // Precompensation shift register
  // ****************
  logic [`MFMPC_SR_W-1:0] sr;
  logic [2:0] busy;

  // Busy shifter stalls the buffer rather than dropping a bit
  assign buf_pop = shift_tick && (busy == '0) && buf_out_valid;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sr <= '0;
      busy <= '0;
    end else if (buf_pop) begin
      sr[`MFMPC_STAGE_A] <= buf_cmd[0];
      sr[`MFMPC_STAGE_B] <= !buf_cmd[1] && !buf_cmd[0];
      sr[`MFMPC_STAGE_C] <= buf_cmd[1];
      sr[`MFMPC_STAGE_D] <= 1'b0;
      busy <= 3'(`MFMPC_BUSY_TICKS);
    end else if (shift_tick) begin
      sr <= {1'b0, sr[`MFMPC_SR_W-1:1]};
      if (busy != '0) begin
        busy <= busy - 1'b1;
      end
    end
  end

  assign last_stage_out_n_o = !sr[`MFMPC_STAGE_D];
  assign write_data_o = 1'b0;
  assign write_data_oe_n_o = !last_stage_out_n_o;

  // ****************
  // Checks
  // ****************
  a_lower_on_clk: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_ff && !data_ff) |=> lower_freq_o)
    else $error("lower pulse missing after clock-first");

  a_raise_on_data: assert property (@(posedge clk_i) disable iff (reset_i)
    (data_ff && !clk_ff) |=> !raise_freq_n_o && !lower_freq_o)
    else $error("raise pulse missing after data-first");

  a_pump_exclusive: assert property (@(posedge clk_i) disable iff (reset_i)
    !(lower_freq_o && !raise_freq_n_o))
    else $error("raise and lower active together");

  a_coinc_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_ff && data_ff) |=> (!clk_ff && !data_ff && det_off) ##1
    (lower_freq_o == 1'b0 && raise_freq_n_o == 1'b1))
    else $error("coincidence did not reset detector");

  a_single_runs: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_ff ^ data_ff) |-> !det_off)
    else $error("detector stopped with one flop set");

  a_cmp_bit: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(comparison_clock_o) |-> $past(osc_cnt[`MFMPC_CMP_BIT], 1) && $past(osc_rise, 2))
    else $error("comparison clock not from counter bit");

  a_idle_source: assert property (@(posedge clk_i) disable iff (reset_i)
    (sel_rise && !f[`MFMPC_P_TRACK]) |-> f[`MFMPC_P_DBL])
    else $error("idle detector input not write clock");

  a_early_exit: assert property (@(posedge clk_i) disable iff (reset_i)
    (buf_pop && buf_cmd[1]) |=> ##[1:TICK_SPAN] sr[`MFMPC_STAGE_D])
    else $error("early bit late at last stage");

  a_load_synced: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(push_valid) |-> $past(state == P_SETTLE) && $past(shift_tick))
    else $error("load without sync and settle");

  c_coinc: cover property (@(posedge clk_i) disable iff (reset_i) clk_ff && data_ff);
  c_lower: cover property (@(posedge clk_i) disable iff (reset_i) $rose(lower_freq_o));
  c_raise: cover property (@(posedge clk_i) disable iff (reset_i) $fell(raise_freq_n_o));
  c_late: cover property (@(posedge clk_i) disable iff (reset_i) buf_pop && buf_cmd[0]);
endmodule
`default_nettype wire
